// ==== logic/ccu_pkg.sv ====
// shared constants and carriers for the two-channel capture/compare unit
package ccu_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h20;
    localparam logic [7:0] OFS_CNT_HI  = 8'h21;
    localparam logic [7:0] OFS_CNT_LO  = 8'h22;
    localparam logic [7:0] OFS_MOD_HI  = 8'h23;
    localparam logic [7:0] OFS_MOD_LO  = 8'h24;
    localparam logic [7:0] OFS_CH0_CTL = 8'h25;
    localparam logic [7:0] OFS_CH0_HI  = 8'h26;
    localparam logic [7:0] OFS_CH0_LO  = 8'h27;
    localparam logic [7:0] OFS_CH1_CTL = 8'h28;
    localparam logic [7:0] OFS_CH1_HI  = 8'h29;
    localparam logic [7:0] OFS_CH1_LO  = 8'h2A;

    // counter_status_control field positions
    localparam int CTRL_OVF_FLAG  = 7;
    localparam int CTRL_OVF_IE    = 6;
    localparam int CTRL_HALT      = 5;
    localparam int CTRL_CNT_RESET = 4;
    localparam int CTRL_DIV_MSB   = 2;

    // reset values and codes
    localparam logic        HALT_RST    = 1'b1;
    localparam logic [2:0]  DIV_RST     = 3'h0;
    localparam logic [2:0]  DIV_EXT     = 3'h7;
    localparam logic [15:0] MOD_RST     = 16'hFFFF;
    localparam logic [15:0] CNT_RST     = 16'h0000;
    localparam logic [7:0]  CHCTL_RST   = 8'h00;

    // edge/level codes
    localparam logic [1:0]  ELS_NONE    = 2'h0;
    localparam logic [1:0]  ELS_TOGGLE  = 2'h1;
    localparam logic [1:0]  ELS_CLEAR   = 2'h2;
    localparam logic [1:0]  ELS_SET     = 2'h3;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ccu_bus_t;

    // channel control byte, bit 7 down to bit 0
    typedef struct packed {
        logic       channel_event_flag;
        logic       channel_irq_enable;
        logic       buffered_mode_bit;
        logic       compare_mode_bit;
        logic       edge_level_select_hi;
        logic       edge_level_select_lo;
        logic       toggle_on_wrap;
        logic       full_duty_force;
    } ccu_chctl_t;

endpackage

// ==== logic/ccu_top.sv ====
// two-channel capture/compare/pwm unit with modulo counter and register port
`timescale 1ns/1ns
module ccu_top (
    input  wire logic              i_core_clk,
    input  wire logic              i_arst_n,
    input  wire ccu_pkg::ccu_bus_t i_bus,
    output logic [7:0]             o_rdata,
    input  wire logic              i_break,
    input  wire logic              i_ext_clk,
    output logic                   o_ext_clk_in_force,
    input  wire logic [1:0]        i_ch_pin,
    output logic [1:0]             o_ch_pin,
    output logic [1:0]             o_ch_oe,
    output logic                   o_ovf_irq,
    output logic [1:0]             o_ch_irq
);
    import ccu_pkg::*;

    logic             overflow_flag;
    logic             overflow_irq_enable;
    logic             counter_halt;
    logic [2:0]       clock_divider_select;
    logic [5:0]       presc;
    logic [5:0]       div_mask;
    logic [15:0]      count;
    logic [15:0]      next_count;
    logic [15:0]      mod_limit;
    logic [7:0]       cnt_lo_buf;
    logic             cnt_latched;
    logic             mod_lock;
    logic             ovf_armed;
    logic             ext_sync1;
    logic             ext_sync2;
    logic             ext_prev;
    logic             ext_rise;
    logic             advance;
    logic             presc_tick;
    logic             cnt_tick;
    logic             wrap;
    logic             ovf_evt;
    logic             buffered;
    logic             act_sel;
    logic             last_wr;
    logic             wr_ctrl;
    logic             rd_ctrl;
    logic             cnt_reset;
    logic [7:0]       next_rdata;
    ccu_chctl_t       ch_ctl [2];
    logic [15:0]      ch_val [2];
    logic [1:0]       wr_ctl;
    logic [1:0]       wr_hi;
    logic [1:0]       wr_lo;
    logic [1:0]       rd_ctl;
    logic [1:0]       rd_hi;
    logic [1:0]       rd_lo;
    logic [1:0]       cap_lock;
    logic [1:0]       cmp_lock;
    logic [1:0]       flag_armed;
    logic [1:0]       pin_prev;
    logic [1:0]       max_eff;
    logic [1:0]       out_lvl;

    // register decode
    assign wr_ctrl   = i_bus.wr && (i_bus.addr == OFS_CTRL);
    assign rd_ctrl   = i_bus.rd && (i_bus.addr == OFS_CTRL);
    assign cnt_reset = wr_ctrl && i_bus.wdata[CTRL_CNT_RESET];
    assign wr_ctl    = {2{i_bus.wr}} & {i_bus.addr == OFS_CH1_CTL, i_bus.addr == OFS_CH0_CTL};
    assign wr_hi     = {2{i_bus.wr}} & {i_bus.addr == OFS_CH1_HI, i_bus.addr == OFS_CH0_HI};
    assign wr_lo     = {2{i_bus.wr}} & {i_bus.addr == OFS_CH1_LO, i_bus.addr == OFS_CH0_LO};
    assign rd_ctl    = {2{i_bus.rd}} & {i_bus.addr == OFS_CH1_CTL, i_bus.addr == OFS_CH0_CTL};
    assign rd_hi     = {2{i_bus.rd}} & {i_bus.addr == OFS_CH1_HI, i_bus.addr == OFS_CH0_HI};
    assign rd_lo     = {2{i_bus.rd}} & {i_bus.addr == OFS_CH1_LO, i_bus.addr == OFS_CH0_LO};
    assign buffered  = ch_ctl[0].buffered_mode_bit;

    // counter clocking: code 7 wraps the shift to seven and zeroes the mask, harmless since ext is used
    // break freezes both prescaler and counter
    assign advance    = !counter_halt && !i_break;
    assign div_mask   = 6'h3F >> (3'h6 - clock_divider_select);
    assign presc_tick = (presc & div_mask) == div_mask;
    // edge taken between second and third stage only
    assign ext_rise   = ext_sync2 && !ext_prev;
    assign cnt_tick   = advance && ((clock_divider_select == DIV_EXT) ? ext_rise : presc_tick);
    assign wrap       = cnt_tick && (count == mod_limit);
    assign next_count = wrap ? CNT_RST : count + 16'h0001;
    // flag held off while modulo is half written
    assign ovf_evt    = wrap && !mod_lock;

    // external clock synchroniser and edge history
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev  <= 1'b0;
        end else begin
            ext_sync1 <= i_ext_clk;
            ext_sync2 <= ext_sync1;
            ext_prev  <= ext_sync2;
        end
    end

    // prescaler
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            presc <= 6'h00;
        end else if (cnt_reset) begin
            presc <= 6'h00;
        end else if (advance) begin
            presc <= presc + 6'h01;
        end
    end

    // main counter; reset strobe beats a tick so halt+reset parks at zero
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= CNT_RST;
        // reset strobe wins in the same write as halt
        end else if (cnt_reset) begin
            count <= CNT_RST;
        end else if (cnt_tick) begin
            count <= next_count;
        end
    end

    // control fields of counter_status_control
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            overflow_irq_enable  <= 1'b0;
            counter_halt         <= HALT_RST;
            clock_divider_select <= DIV_RST;
        end else if (wr_ctrl) begin
            overflow_irq_enable  <= i_bus.wdata[CTRL_OVF_IE];
            counter_halt         <= i_bus.wdata[CTRL_HALT];
            clock_divider_select <= i_bus.wdata[CTRL_DIV_MSB:0];
        end
    end

    // overflow flag with read-then-write-zero clearing; set wins
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            overflow_flag <= 1'b0;
            ovf_armed     <= 1'b0;
        end else begin
            // fresh overflow disarms the pending clear
            if (ovf_evt) begin
                overflow_flag <= 1'b1;
                ovf_armed     <= 1'b0;
            end else if (wr_ctrl) begin
                if (ovf_armed && !i_bus.wdata[CTRL_OVF_FLAG]) begin
                    overflow_flag <= 1'b0;
                end
                ovf_armed <= 1'b0;
            end else if (rd_ctrl && overflow_flag) begin
                ovf_armed <= 1'b1;
            end
        end
    end

    // modulo limit and its half-written guard
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mod_limit <= MOD_RST;
            mod_lock  <= 1'b0;
        // high write arms the guard, low write drops it
        end else if (i_bus.wr && i_bus.addr == OFS_MOD_HI) begin
            mod_limit[15:8] <= i_bus.wdata;
            mod_lock        <= 1'b1;
        end else if (i_bus.wr && i_bus.addr == OFS_MOD_LO) begin
            mod_limit[7:0] <= i_bus.wdata;
            mod_lock       <= 1'b0;
        end
    end

    // low count latch for coherent 16-bit reads
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_lo_buf  <= 8'h00;
            cnt_latched <= 1'b0;
        end else if (cnt_reset) begin
            cnt_lo_buf  <= 8'h00;
            cnt_latched <= 1'b0;
        // repeat high reads keep the first snapshot
        end else if (i_bus.rd && i_bus.addr == OFS_CNT_HI && !cnt_latched) begin
            cnt_lo_buf  <= count[7:0];
            cnt_latched <= 1'b1;
        end else if (i_bus.rd && i_bus.addr == OFS_CNT_LO) begin
            cnt_latched <= 1'b0;
        end
    end

    // buffered pair: which value set drives channel 0's pin
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            act_sel <= 1'b0;
            last_wr <= 1'b0;
        end else if (!buffered) begin
            act_sel <= 1'b0;
            last_wr <= 1'b0;
        end else begin
            // swap only at overflow so a period is never cut short
            if (wr_lo[1]) begin
                last_wr <= 1'b1;
            end else if (wr_lo[0]) begin
                last_wr <= 1'b0;
            end
            if (wrap) begin
                act_sel <= last_wr;
            end
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_ch
            logic       dis;
            logic       capture;
            logic       cmp_mode;
            logic [1:0] els;
            logic       cap_evt;
            logic       cmp_evt;
            logic       tov_on;
            logic       pulse_lvl;
            logic [15:0] cmp_val;
            logic        lock_now;

            // channel 1 is idle while the pair is buffered
            assign dis      = (i == 1) && buffered;
            assign els      = {ch_ctl[i].edge_level_select_hi, ch_ctl[i].edge_level_select_lo};
            assign cmp_mode = !dis && (ch_ctl[i].compare_mode_bit || ch_ctl[i].buffered_mode_bit);
            assign capture  = !dis && !cmp_mode && (els != ELS_NONE);
            assign cmp_val  = (i == 0 && buffered) ? ch_val[act_sel] : ch_val[i];
            assign lock_now = (i == 0 && buffered) ? cmp_lock[act_sel] : cmp_lock[i];
            // rising on low code bit, falling on high code bit
            assign cap_evt  = capture && ((els[0] && i_ch_pin[i] && !pin_prev[i])
                                       || (els[1] && !i_ch_pin[i] && pin_prev[i]));
            // match blocked while value half written
            assign cmp_evt  = cmp_mode && cnt_tick && (next_count == cmp_val) && !lock_now;
            // wrap toggle only in compare mode
            assign tov_on   = cmp_mode && ch_ctl[i].toggle_on_wrap && wrap;
            assign pulse_lvl = (els == ELS_CLEAR) ? 1'b1 : (els == ELS_SET) ? 1'b0 : !out_lvl[i];

            // control byte and event flag
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    ch_ctl[i]     <= CHCTL_RST;
                    flag_armed[i] <= 1'b0;
                end else begin
                    if (wr_ctl[i] && !dis) begin
                        ch_ctl[i].channel_irq_enable   <= i_bus.wdata[6];
                        // buffered bit exists only in channel 0
                        ch_ctl[i].buffered_mode_bit    <= (i == 0) ? i_bus.wdata[5] : 1'b0;
                        ch_ctl[i].compare_mode_bit     <= i_bus.wdata[4];
                        ch_ctl[i].edge_level_select_hi <= i_bus.wdata[3];
                        ch_ctl[i].edge_level_select_lo <= i_bus.wdata[2];
                        ch_ctl[i].toggle_on_wrap       <= i_bus.wdata[1];
                        ch_ctl[i].full_duty_force      <= i_bus.wdata[0];
                    end
                    if (cap_evt || cmp_evt) begin
                        ch_ctl[i].channel_event_flag <= 1'b1;
                        flag_armed[i]                <= 1'b0;
                    end else if (wr_ctl[i] && !dis) begin
                        if (flag_armed[i] && !i_bus.wdata[7]) begin
                            ch_ctl[i].channel_event_flag <= 1'b0;
                        end
                        flag_armed[i] <= 1'b0;
                    end else if (rd_ctl[i] && ch_ctl[i].channel_event_flag) begin
                        flag_armed[i] <= 1'b1;
                    end
                end
            end

            // value registers have no defined reset state
            always_ff @(posedge i_core_clk) begin
                if (wr_hi[i]) begin
                    ch_val[i][15:8] <= i_bus.wdata;
                end else if (wr_lo[i]) begin
                    ch_val[i][7:0] <= i_bus.wdata;
                // capture held off while high byte read pending
                end else if (cap_evt && !cap_lock[i]) begin
                    ch_val[i] <= count;
                end
            end

            // half-access guards on the value registers
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    cap_lock[i] <= 1'b0;
                    cmp_lock[i] <= 1'b0;
                end else begin
                    // guard set by high read in capture setting
                    if (rd_hi[i] && !ch_ctl[i].compare_mode_bit && !buffered) begin
                        cap_lock[i] <= 1'b1;
                    end else if (rd_lo[i]) begin
                        cap_lock[i] <= 1'b0;
                    end
                    // guard set by high write in any compare setting
                    if (wr_hi[i] && (ch_ctl[i].compare_mode_bit || buffered)) begin
                        cmp_lock[i] <= 1'b1;
                    end else if (wr_lo[i]) begin
                        cmp_lock[i] <= 1'b0;
                    end
                end
            end

            // pin level, drive enable and full-duty latch
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    out_lvl[i]  <= 1'b1;
                    max_eff[i]  <= 1'b0;
                    o_ch_oe[i]  <= 1'b0;
                    pin_prev[i] <= 1'b0;
                end else begin
                    pin_prev[i] <= i_ch_pin[i];
                    // pin released to port unless compare mode has an action code set
                    o_ch_oe[i]  <= !dis && cmp_mode && (els != ELS_NONE);
                    // full duty sampled at overflow, so it acts next period
                    if (wrap) begin
                        max_eff[i] <= ch_ctl[i].full_duty_force && ch_ctl[i].toggle_on_wrap;
                    end
                    // preset level, compare bit set gives low
                    if (els == ELS_NONE || dis) begin
                        out_lvl[i] <= !ch_ctl[i].compare_mode_bit;
                    end else if (tov_on) begin
                        out_lvl[i] <= ch_ctl[i].full_duty_force ? pulse_lvl : !out_lvl[i];
                    end else if (cmp_evt && !max_eff[i]) begin
                        unique case (els)
                            ELS_TOGGLE: out_lvl[i] <= !out_lvl[i];
                            ELS_CLEAR:  out_lvl[i] <= 1'b0;
                            ELS_SET:    out_lvl[i] <= 1'b1;
                            ELS_NONE:   out_lvl[i] <= out_lvl[i];
                        endcase
                    end
                end
            end

            // channel request follows flag and enable
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    o_ch_irq[i] <= 1'b0;
                end else begin
                    o_ch_irq[i] <= ch_ctl[i].channel_event_flag && ch_ctl[i].channel_irq_enable;
                end
            end

            assign o_ch_pin[i] = out_lvl[i];
        end
    endgenerate

    // read mux; counter reset bit always reads zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (i_bus.addr)
            OFS_CTRL:    next_rdata = {overflow_flag, overflow_irq_enable, counter_halt,
                                       2'h0, clock_divider_select};
            OFS_CNT_HI:  next_rdata = count[15:8];
            OFS_CNT_LO:  next_rdata = cnt_latched ? cnt_lo_buf : count[7:0];
            OFS_MOD_HI:  next_rdata = mod_limit[15:8];
            OFS_MOD_LO:  next_rdata = mod_limit[7:0];
            OFS_CH0_CTL: next_rdata = ch_ctl[0];
            OFS_CH0_HI:  next_rdata = ch_val[0][15:8];
            OFS_CH0_LO:  next_rdata = ch_val[0][7:0];
            OFS_CH1_CTL: next_rdata = ch_ctl[1];
            OFS_CH1_HI:  next_rdata = ch_val[1][15:8];
            OFS_CH1_LO:  next_rdata = ch_val[1][7:0];
            default:     next_rdata = 8'h00;
        endcase
    end

    // registered outputs
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata            <= 8'h00;
            o_ovf_irq          <= 1'b0;
            o_ext_clk_in_force <= 1'b0;
        end else begin
            o_rdata            <= i_bus.rd ? next_rdata : 8'h00;
            o_ovf_irq          <= overflow_flag && overflow_irq_enable;
            // tells the port logic to hold the clock pin as input
            o_ext_clk_in_force <= clock_divider_select == DIV_EXT;
        end
    end

endmodule

// ==== verif/ccu_pin_model.sv ====
// far-side pins: external count clock and channel input levels
`timescale 1ns/1ns
module ccu_pin_model (
    input  wire logic  i_core_clk,
    output logic       o_ext_clk,
    output logic [1:0] o_lvl
);
    // clock stands low outside bursts
    initial begin
        o_ext_clk = 1'b0;
        o_lvl     = 2'h0;
    end
    // slow pulses so the synchroniser sees every edge
    task ext_pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge i_core_clk);
            o_ext_clk <= 1'b1;
            repeat (4) @(posedge i_core_clk);
            o_ext_clk <= 1'b0;
        end
    endtask
    // levels seen by channels not driven by the unit
    task drive(input logic [1:0] v);
        o_lvl <= v;
    endtask
endmodule

// ==== verif/ccu_top_props.sv ====
// port assertions for the capture/compare unit
`timescale 1ns/1ns
module ccu_top_props import ccu_pkg::*; (
    input wire logic              i_core_clk,
    input wire logic              i_arst_n,
    input wire ccu_pkg::ccu_bus_t i_bus,
    input wire logic [7:0]        o_rdata,
    input wire logic              o_ext_clk_in_force,
    input wire logic [1:0]        o_ch_oe,
    input wire logic              o_ovf_irq,
    input wire logic [1:0]        o_ch_irq
);
    // bus decodes: control byte writes, divider code and count low read
    wire logic wc = i_bus.wr && i_bus.addr == OFS_CTRL;
    wire logic w0 = i_bus.wr && i_bus.addr == OFS_CH0_CTL;
    wire logic wx = i_bus.wdata[2:0] == DIV_EXT;
    wire logic rl = i_bus.rd && i_bus.addr == OFS_CNT_LO;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    rst_bit_a: assert property ($past(i_bus.rd && i_bus.addr == OFS_CTRL) |->
        o_rdata[4:3] == 2'h0) else $error("counter reset bit reads set");
    ext_pin_a: assert property (wc |-> ##2 o_ext_clk_in_force == $past(wx, 2))
        else $error("ext pin force does not follow divider code");
    ovf_fall_a: assert property ($fell(o_ovf_irq) |-> $past(wc, 2))
        else $error("overflow irq dropped without control write");
    ch_fall_a: assert property ($fell(o_ch_irq[0]) |-> $past(w0, 2))
        else $error("channel irq dropped without control write");
    oe_off_a: assert property (w0 && (i_bus.wdata[3:2] == 2'h0 ||
        i_bus.wdata[5:4] == 2'h0) |-> ##2 !o_ch_oe[0]) else $error("pin not released");
    oe_on_a: assert property (w0 && i_bus.wdata[4] && i_bus.wdata[3:2] != 2'h0
        |-> ##2 o_ch_oe[0]) else $error("compare pin not driven");
    buf_free_a: assert property (w0 && i_bus.wdata[5] |-> ##2 !o_ch_oe[1])
        else $error("channel 1 pin still driven");
    halt_zero_a: assert property (wc && i_bus.wdata[5:4] == 2'h3 ##2 rl |=>
        o_rdata == 8'h00) else $error("halted count not zero");
endmodule
bind ccu_top ccu_top_props i_ccu_top_props (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_bus(i_bus), .o_rdata(o_rdata), .o_ext_clk_in_force(o_ext_clk_in_force),
    .o_ch_oe(o_ch_oe), .o_ovf_irq(o_ovf_irq), .o_ch_irq(o_ch_irq));

// ==== verif/ccu_top_bench.sv ====
// self-checking bench for the capture/compare unit
`timescale 1ns/1ns
module ccu_top_bench;
    import ccu_pkg::*;
    logic       i_core_clk;
    logic       i_arst_n;
    ccu_bus_t   i_bus;
    logic       i_break;
    logic       ext_clk;
    logic [1:0] lvl;
    logic [7:0] o_rdata;
    logic       o_ext_clk_in_force;
    logic [1:0] o_ch_pin;
    logic [1:0] o_ch_oe;
    logic       o_ovf_irq;
    logic [1:0] o_ch_irq;
    int         n_mismatch = 0;
    int         checked = 0;
    // pin level: the unit wins where it drives
    wire logic [1:0] pin_in = (o_ch_oe & o_ch_pin) | (~o_ch_oe & lvl);
    ccu_top i_ccu_top (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_bus(i_bus),
        .o_rdata(o_rdata), .i_break(i_break), .i_ext_clk(ext_clk),
        .o_ext_clk_in_force(o_ext_clk_in_force), .i_ch_pin(pin_in), .o_ch_pin(o_ch_pin),
        .o_ch_oe(o_ch_oe), .o_ovf_irq(o_ovf_irq), .o_ch_irq(o_ch_irq));
    ccu_pin_model i_ccu_pin_model (.i_core_clk(i_core_clk), .o_ext_clk(ext_clk), .o_lvl(lvl));
    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end
    // values are copied at the call, so callers wait for the edge's updates first
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle cycle after each strobe keeps drivers single-assigned
    task wr(input logic [7:0] a, input logic [7:0] d);
        i_bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_core_clk);
        i_bus <= '0;
        @(posedge i_core_clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        i_bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_core_clk);
        i_bus <= '0;
        @(negedge i_core_clk);
        chk(o_rdata, exp);
        @(posedge i_core_clk);
    endtask
    task idle(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task s_count;
        rd(OFS_CTRL, 8'h20);
        rd(8'h30, 8'h00);
        rd(OFS_MOD_HI, 8'hFF);
        for (int d = 0; d < 7; d++) begin
            wr(OFS_CTRL, 8'h30);
            rd(OFS_CNT_LO, 8'h00);
            wr(OFS_CTRL, 8'(d));
            idle(62);
            wr(OFS_CTRL, 8'h20);
            rd(OFS_CNT_LO, 8'(64 >> d));
        end
        i_break <= 1'b1;
        wr(OFS_CTRL, 8'h00);
        idle(3);
        wr(OFS_CTRL, 8'h20);
        i_break <= 1'b0;
        rd(OFS_CNT_HI, 8'h00);
        wr(OFS_CTRL, 8'h00);
        idle(3);
        wr(OFS_CTRL, 8'h20);
        rd(OFS_CNT_HI, 8'h00);
        rd(OFS_CNT_LO, 8'h01);
        rd(OFS_CNT_LO, 8'h06);
    endtask
    task s_ovf;
        wr(OFS_CTRL, 8'h30);
        wr(OFS_MOD_HI, 8'h00);
        wr(OFS_MOD_LO, 8'h04);
        wr(OFS_CTRL, 8'h40);
        idle(10);
        wr(OFS_CTRL, 8'hE0);
        rd(OFS_CNT_LO, 8'h02);
        #1 chk(o_ovf_irq, 1'b1);
        rd(OFS_CTRL, 8'hE0);
        wr(OFS_CTRL, 8'h60);
        rd(OFS_CTRL, 8'h60);
        #1 chk(o_ovf_irq, 1'b0);
        wr(OFS_MOD_HI, 8'h00);
        wr(OFS_CTRL, 8'h40);
        idle(10);
        wr(OFS_CTRL, 8'h60);
        rd(OFS_CTRL, 8'h60);
        wr(OFS_MOD_LO, 8'h04);
        wr(OFS_CTRL, 8'h40);
        idle(10);
        wr(OFS_CTRL, 8'h60);
        rd(OFS_CTRL, 8'hE0);
    endtask
    task s_chan;
        wr(OFS_CTRL, 8'h30);
        wr(OFS_MOD_HI, 8'hFF);
        wr(OFS_MOD_LO, 8'hFF);
        wr(OFS_CH0_CTL, 8'h50);
        #1 chk(o_ch_pin[0], 1'b0);
        wr(OFS_CH0_HI, 8'h00);
        wr(OFS_CH0_LO, 8'h08);
        wr(OFS_CH0_CTL, 8'h5C);
        wr(OFS_CTRL, 8'h00);
        idle(4);
        #1 chk(o_ch_pin[0], 1'b0);
        idle(6);
        #1 chk(o_ch_pin[0], 1'b1);
        chk(o_ch_irq[0], 1'b1);
        rd(OFS_CH0_CTL, 8'hDC);
        wr(OFS_CH0_CTL, 8'h5C);
        #1 chk(o_ch_irq[0], 1'b0);
        wr(OFS_CH1_CTL, 8'h04);
        i_ccu_pin_model.drive(2'h2);
        idle(3);
        rd(OFS_CH1_CTL, 8'h84);
        wr(OFS_CH0_CTL, 8'h20);
        wr(OFS_CH1_CTL, 8'h10);
        rd(OFS_CH1_CTL, 8'h84);
        wr(OFS_CTRL, 8'h37);
        wr(OFS_CTRL, 8'h07);
        i_ccu_pin_model.ext_pulses(4);
        idle(6);
        wr(OFS_CTRL, 8'h27);
        rd(OFS_CNT_LO, 8'h04);
        #1 chk(o_ext_clk_in_force, 1'b1);
    endtask
    // clear-on-compare pwm, wrap toggle, then full duty from the next period
    task s_pwm;
        wr(OFS_CTRL, 8'h30);
        wr(OFS_MOD_HI, 8'h00);
        wr(OFS_MOD_LO, 8'h0F);
        wr(OFS_CH0_CTL, 8'h1A);
        wr(OFS_CTRL, 8'h00);
        idle(10);
        #1 chk(o_ch_pin[0], 1'b0);
        idle(7);
        #1 chk(o_ch_pin[0], 1'b1);
        wr(OFS_CH0_CTL, 8'h1B);
        idle(6);
        #1 chk(o_ch_pin[0], 1'b0);
        idle(14);
        #1 chk(o_ch_pin[0], 1'b1);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        i_arst_n = 1'b0;
        i_bus = '0;
        i_break = 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        @(posedge i_core_clk);
        s_count;
        s_ovf;
        s_chan;
        s_pwm;
        stop_test;
    end
endmodule
